// >>> src/scm_defs.svh
// Offsets, field positions, reset values and timing counts of the clock control block
`ifndef SCM_DEFS_SVH
`define SCM_DEFS_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define SCM_ADDR_CLOCK_CONTROL 8'hB2
`define SCM_ADDR_IRQ_STATUS 8'hB3
`define SCM_ADDR_IRQ_MASK 8'hB4
`define SCM_ADDR_STATE 8'hB5

// ----------------------------------------------------------------------------
// Field positions of clock_control
// ----------------------------------------------------------------------------
`define SCM_BIT_BOOST 7
`define SCM_BIT_DIV_HI 6
`define SCM_BIT_DIV_LO 5
`define SCM_BIT_FAIL 4
`define SCM_BIT_RC_POWER 3
`define SCM_BIT_RC_SELECT 2

// ----------------------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------------------
`define SCM_RST_BOOST 1'h1
`define SCM_RST_DIV 2'h3
`define SCM_OPT_XTAL32K 3'h3
`define SCM_OPT_INT_RC 3'h4
`define SCM_DIV1_CYC 4'h0
`define SCM_DIV2_CYC 4'h1
`define SCM_DIV4_CYC 4'h3
`define SCM_DIV12_CYC 4'hB

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
// Oscillator edges missing for this many clk cycles means failure
`define SCM_FAIL_TIMEOUT 8'h40
// Edges seen in a row before the oscillator counts as back
`define SCM_RECOVER_EDGES 4'h8

`endif

// >>> src/scm_pkg.sv
// Types shared by the clock control block
package scm_pkg;

  typedef enum logic [1:0] {
    SCM_DIV_1 = 2'h0,
    SCM_DIV_2 = 2'h1,
    SCM_DIV_4 = 2'h2,
    SCM_DIV_12 = 2'h3
  } scm_div_e;

  typedef enum logic [1:0] {
    SCM_ST_NORMAL = 2'h0,
    SCM_ST_FAILED = 2'h1,
    SCM_ST_OFF = 2'h2
  } scm_mon_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } scm_bus_s;

  typedef struct packed {
    logic xtal_startup_boost;
    scm_div_e cpu_clock_divider_select;
    logic internal_rc_power;
    logic internal_rc_select;
  } scm_cfg_s;

endpackage

// >>> src/scm_clock_control.sv
// System clock control register, prescaler select and clock failure monitor
//
// Contract
// - Every reset sets the startup boost bit 7 to one.
// - Software writes boost: 0 normal oscillator mode, 1 boosted startup.
// - Boost takes effect only when oscillator type option is 011.
// - RC power bit 3: 0 turns internal RC off, 1 turns it on.
// - RC power and select only act when oscillator type option is 011.
// - With RC power and select both one, clearing RC power is ignored.
// - Monitor is disabled while internal RC is the prescaler input.
// - On oscillator failure substitute watchdog RC clock and set fail flag.
// - Monitor interrupt requested when flag set and both enables active.
// - When oscillator returns, switch back and clear the flag by hardware.
// - Fail flag bit 4 is read-only; software writes are ignored.
// - On flag clear, the previous clock configuration is restored.
// - Monitor does not operate when option selects internal RC.
// - Fail flag reads 0 while clock normal, 1 while failed.
// - Prescaler input is oscillator clock or internal RC; output is cpu clock.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`include "scm_defs.svh"

module scm_clock_control
  import scm_pkg::*;
#(
  parameter int FAIL_TIMEOUT = `SCM_FAIL_TIMEOUT
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire scm_bus_s bus,
  output logic [7:0] rdata,
  input wire logic [2:0] oscillator_type_option,
  input wire logic oscillator_clock,
  input wire logic internal_rc_clock,
  input wire logic watchdog_rc_clock,
  input wire logic global_irq_enable,
  input wire logic monitor_irq_enable,
  output logic monitor_irq,
  output logic irq,
  output logic xtal_boost_en,
  output logic internal_rc_en,
  output logic [1:0] prescaler_src,
  output logic cpu_clock_tick,
  output logic clock_fail_flag
);

  if (FAIL_TIMEOUT < 2 || FAIL_TIMEOUT > 255) begin : g_timeout_range
    $error("FAIL_TIMEOUT out of range");
  end

  // --------------------------------------------------------------------------
  // Reset release and input synchronisers
  // --------------------------------------------------------------------------
  logic rst_s1_r, rst_sync_n;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_r <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_sync_n <= rst_s1_r;
    end
  end

  logic [4:0] pin_s1_r, pin_s2_r;
  logic [2:0] opt_s1_r, opt_s2_r;
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pin_s1_r <= 5'h00;
      pin_s2_r <= 5'h00;
      opt_s1_r <= 3'h0;
      opt_s2_r <= 3'h0;
    end else begin
      // Each enable gets its own synchroniser; no logic ahead of the first stage
      pin_s1_r <= {oscillator_clock, internal_rc_clock, watchdog_rc_clock,
                   global_irq_enable, monitor_irq_enable};
      pin_s2_r <= pin_s1_r;
      opt_s1_r <= oscillator_type_option;
      opt_s2_r <= opt_s1_r;
    end
  end

  wire osc_s = pin_s2_r[4];
  wire irq_en_s = pin_s2_r[1] && pin_s2_r[0];
  wire opt_xtal = (opt_s2_r == `SCM_OPT_XTAL32K);
  wire opt_rc = (opt_s2_r == `SCM_OPT_INT_RC);

  // --------------------------------------------------------------------------
  // Configuration register
  // --------------------------------------------------------------------------
  scm_cfg_s cfg_r;
  wire wr_ctl = bus.wr && (bus.addr == `SCM_ADDR_CLOCK_CONTROL);
  wire wr_mask = bus.wr && (bus.addr == `SCM_ADDR_IRQ_MASK);
  wire rd_stat = bus.rd && (bus.addr == `SCM_ADDR_IRQ_STATUS);
  wire rc_in_use = cfg_r.internal_rc_power && cfg_r.internal_rc_select;
  // Clearing RC power while RC feeds the prescaler would kill the clock
  wire rc_power_nxt = (rc_in_use && !bus.wdata[`SCM_BIT_RC_POWER]) ? 1'b1
                      : bus.wdata[`SCM_BIT_RC_POWER];

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cfg_r.xtal_startup_boost <= `SCM_RST_BOOST;
      cfg_r.cpu_clock_divider_select <= scm_div_e'(`SCM_RST_DIV);
      cfg_r.internal_rc_power <= 1'b0;
      cfg_r.internal_rc_select <= 1'b0;
    end else if (wr_ctl) begin
      cfg_r.xtal_startup_boost <= bus.wdata[`SCM_BIT_BOOST];
      cfg_r.cpu_clock_divider_select <=
        scm_div_e'(bus.wdata[`SCM_BIT_DIV_HI:`SCM_BIT_DIV_LO]);
      cfg_r.internal_rc_power <= rc_power_nxt;
      cfg_r.internal_rc_select <= bus.wdata[`SCM_BIT_RC_SELECT];
    end
  end

  assign xtal_boost_en = cfg_r.xtal_startup_boost && opt_xtal;
  assign internal_rc_en = cfg_r.internal_rc_power && opt_xtal;
  wire rc_feeds = rc_in_use && opt_xtal;

  // --------------------------------------------------------------------------
  // Clock failure monitor
  // --------------------------------------------------------------------------
  scm_mon_e mon_r, mon_nxt;
  logic osc_d_r;
  logic [7:0] gap_r;
  logic [3:0] good_r;
  wire osc_edge = osc_s && !osc_d_r;
  wire mon_off = rc_feeds || opt_rc;
  wire timeout = (gap_r >= 8'(FAIL_TIMEOUT - 1));

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      osc_d_r <= 1'b0;
      gap_r <= 8'h0;
      good_r <= 4'h0;
    end else begin
      osc_d_r <= osc_s;
      gap_r <= (osc_edge || mon_off) ? 8'h0 : (timeout ? gap_r : gap_r + 8'h1);
      good_r <= (timeout || mon_off) ? 4'h0
                : (osc_edge && good_r != `SCM_RECOVER_EDGES) ? good_r + 4'h1 : good_r;
    end
  end

  always_comb begin
    mon_nxt = mon_r;
    case (mon_r)
      SCM_ST_NORMAL: begin
        if (mon_off) begin
          mon_nxt = SCM_ST_OFF;
        end else if (timeout) begin
          mon_nxt = SCM_ST_FAILED;
        end
      end
      SCM_ST_FAILED: begin
        if (mon_off || good_r == `SCM_RECOVER_EDGES) begin
          mon_nxt = SCM_ST_NORMAL;
        end
      end
      SCM_ST_OFF: begin
        if (!mon_off) begin
          mon_nxt = SCM_ST_NORMAL;
        end
      end
      default: mon_nxt = SCM_ST_NORMAL;
    endcase
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      mon_r <= SCM_ST_NORMAL;
    end else begin
      mon_r <= mon_nxt;
    end
  end

  // Only hardware moves the flag; the configuration register is untouched
  // during a failure, so leaving it restores the earlier setup
  assign clock_fail_flag = (mon_r == SCM_ST_FAILED);
  // 0 oscillator, 1 internal RC, 2 watchdog RC substitute
  assign prescaler_src = clock_fail_flag ? 2'h2 : (rc_feeds ? 2'h1 : 2'h0);

  // --------------------------------------------------------------------------
  // Prescaler: one tick per divided cpu clock period, counted on clk
  // --------------------------------------------------------------------------
  logic [3:0] div_cnt_r, div_top;
  always_comb begin
    case (cfg_r.cpu_clock_divider_select)
      SCM_DIV_1: div_top = `SCM_DIV1_CYC;
      SCM_DIV_2: div_top = `SCM_DIV2_CYC;
      SCM_DIV_4: div_top = `SCM_DIV4_CYC;
      SCM_DIV_12: div_top = `SCM_DIV12_CYC;
      default: div_top = `SCM_DIV12_CYC;
    endcase
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      div_cnt_r <= 4'h0;
      cpu_clock_tick <= 1'b0;
    end else begin
      div_cnt_r <= (div_cnt_r >= div_top) ? 4'h0 : div_cnt_r + 4'h1;
      cpu_clock_tick <= (div_cnt_r >= div_top);
    end
  end

  // --------------------------------------------------------------------------
  // Interrupt status, mask and read port
  // --------------------------------------------------------------------------
  logic fail_d_r, stat_fail_r, stat_back_r, mask_fail_r, mask_back_r;
  wire ev_fail = clock_fail_flag && !fail_d_r;
  wire ev_back = !clock_fail_flag && fail_d_r;

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      fail_d_r <= 1'b0;
      stat_fail_r <= 1'b0;
      stat_back_r <= 1'b0;
      mask_fail_r <= 1'b0;
      mask_back_r <= 1'b0;
    end else begin
      fail_d_r <= clock_fail_flag;
      // A new event wins over the clear-on-read
      stat_fail_r <= ev_fail || (stat_fail_r && !rd_stat);
      stat_back_r <= ev_back || (stat_back_r && !rd_stat);
      if (wr_mask) begin
        mask_fail_r <= bus.wdata[0];
        mask_back_r <= bus.wdata[1];
      end
    end
  end

  assign monitor_irq = clock_fail_flag && irq_en_s;
  assign irq = (stat_fail_r && mask_fail_r) || (stat_back_r && mask_back_r);

  wire [7:0] ctl_view = {cfg_r.xtal_startup_boost, cfg_r.cpu_clock_divider_select,
                         clock_fail_flag, cfg_r.internal_rc_power,
                         cfg_r.internal_rc_select, 2'h0};
  logic [7:0] rdata_nxt;
  always_comb begin
    case (bus.addr)
      `SCM_ADDR_CLOCK_CONTROL: rdata_nxt = ctl_view;
      `SCM_ADDR_IRQ_STATUS: rdata_nxt = {6'h00, stat_back_r, stat_fail_r};
      `SCM_ADDR_IRQ_MASK: rdata_nxt = {6'h00, mask_back_r, mask_fail_r};
      `SCM_ADDR_STATE: rdata_nxt = {4'h0, prescaler_src, mon_r};
      default: rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rdata <= 8'h00;
    end else begin
      rdata <= bus.rd ? rdata_nxt : 8'h00;
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  a_boost_reset: assert property (@(posedge clk)
    $rose(rst_sync_n) |-> cfg_r.xtal_startup_boost)
    else $error("boost not set after reset");

  a_boost_write: assert property (@(posedge clk) disable iff (!rst_sync_n)
    wr_ctl |=> cfg_r.xtal_startup_boost == $past(bus.wdata[7]))
    else $error("boost write lost");

  a_boost_gate: assert property (@(posedge clk) disable iff (!rst_sync_n)
    xtal_boost_en |-> opt_xtal)
    else $error("boost active under wrong option");

  a_div_reset: assert property (@(posedge clk)
    $rose(rst_sync_n) |-> cfg_r.cpu_clock_divider_select == SCM_DIV_12)
    else $error("divider reset value wrong");

  // Cycles since the last tick, and whether a control write fell in that span;
  // a write may move the divider, so such a period is not judged
  logic [3:0] tick_gap_r;
  logic tick_wr_r;
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tick_gap_r <= 4'h0;
      tick_wr_r <= 1'b1;
    end else begin
      tick_gap_r <= cpu_clock_tick ? 4'h1
                    : ((tick_gap_r == 4'hF) ? tick_gap_r : tick_gap_r + 4'h1);
      tick_wr_r <= cpu_clock_tick ? wr_ctl : (tick_wr_r || wr_ctl);
    end
  end

  a_div_twelve: assert property (@(posedge clk) disable iff (!rst_sync_n)
    cpu_clock_tick && div_top == `SCM_DIV12_CYC && !tick_wr_r
    |-> tick_gap_r == (`SCM_DIV12_CYC + 4'h1))
    else $error("divide by 12 period wrong");

  a_rc_hold: assert property (@(posedge clk) disable iff (!rst_sync_n)
    wr_ctl && rc_in_use |=> cfg_r.internal_rc_power)
    else $error("RC power cleared while in use");

  a_rc_gate: assert property (@(posedge clk) disable iff (!rst_sync_n)
    !opt_xtal |-> !internal_rc_en && prescaler_src != 2'h1)
    else $error("RC bits acted under wrong option");

  a_mon_off: assert property (@(posedge clk) disable iff (!rst_sync_n)
    mon_off |=> !clock_fail_flag)
    else $error("monitor active while disabled");

  a_fail_detect: assert property (@(posedge clk) disable iff (!rst_sync_n)
    timeout && !mon_off && mon_r == SCM_ST_NORMAL |=> clock_fail_flag ##0 prescaler_src == 2'h2)
    else $error("failure not flagged");

  a_irq_req: assert property (@(posedge clk) disable iff (!rst_sync_n)
    monitor_irq == (clock_fail_flag && $past(global_irq_enable && monitor_irq_enable, 2)))
    else $error("monitor interrupt wrong");

  a_fail_clear: assert property (@(posedge clk) disable iff (!rst_sync_n)
    clock_fail_flag && good_r == `SCM_RECOVER_EDGES |=> !clock_fail_flag)
    else $error("flag not cleared on recovery");

  a_flag_ro: assert property (@(posedge clk) disable iff (!rst_sync_n)
    wr_ctl && !timeout && !mon_off && mon_r == SCM_ST_NORMAL |=> !clock_fail_flag)
    else $error("software moved fail flag");

  a_cfg_keep: assert property (@(posedge clk) disable iff (!rst_sync_n)
    $fell(clock_fail_flag) && !$past(wr_ctl) |-> cfg_r == $past(cfg_r))
    else $error("configuration not restored");

  a_src_fail: assert property (@(posedge clk) disable iff (!rst_sync_n)
    clock_fail_flag |-> prescaler_src == 2'h2)
    else $error("substitute clock not selected");

  a_rc_source: assert property (@(posedge clk) disable iff (!rst_sync_n)
    rc_feeds && !clock_fail_flag |-> prescaler_src == 2'h1)
    else $error("internal RC not feeding prescaler");

  a_flag_read: assert property (@(posedge clk) disable iff (!rst_sync_n)
    bus.rd && bus.addr == `SCM_ADDR_CLOCK_CONTROL
    |=> rdata[`SCM_BIT_FAIL] == $past(clock_fail_flag))
    else $error("fail flag read wrong");

  a_rc_power: assert property (@(posedge clk) disable iff (!rst_sync_n)
    wr_ctl && !rc_in_use |=> cfg_r.internal_rc_power == $past(bus.wdata[`SCM_BIT_RC_POWER]))
    else $error("RC power write lost");

endmodule

// >>> test/scm_clock_control_test.sv
// Self-checking testbench of the clock control register and clock failure monitor
`timescale 1ns/1ps
`include "scm_defs.svh"

module scm_clock_control_test;
  import scm_pkg::*;

  // ----------------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] wdata;
    logic [7:0] rexp;
    logic [7:0] period;
  } scm_row_s;

  localparam scm_bus_s IDLE = '{addr: 8'h00, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  scm_bus_s bus = IDLE;
  logic [7:0] rdata;
  logic [2:0] option = `SCM_OPT_XTAL32K;
  logic osc = 1'b0;
  logic osc_run = 1'b1;
  logic rc_clk = 1'b0;
  logic wdt_clk = 1'b0;
  logic [3:0] osc_div = 4'h0;
  logic gie = 1'b1;
  logic mie = 1'b1;
  logic monitor_irq, irq, xtal_boost_en, internal_rc_en, cpu_clock_tick, clock_fail_flag;
  logic [1:0] prescaler_src;
  int n_errors = 0;
  int n_checks = 0;
  int p;
  // RC is powered one row before it is selected; writing 00 while RC feeds must keep RC power
  scm_row_s rows[8] = '{
    '{8'h00, 8'h00, 8'h01}, '{8'h20, 8'h20, 8'h02}, '{8'h40, 8'h40, 8'h04},
    '{8'h68, 8'h68, 8'h0C}, '{8'hFF, 8'hEC, 8'h0C}, '{8'h00, 8'h08, 8'h01},
    '{8'h80, 8'h80, 8'h01}, '{8'hE0, 8'hE0, 8'h0C}};

  always #10 clk = ~clk;

  // Oscillator is a slow data signal; rising edge every 4 clk cycles while running
  always @(posedge clk) begin
    osc_div <= osc_div + 4'h1;
    rc_clk <= osc_div[0];
    wdt_clk <= osc_div[2];
    if (osc_run && osc_div[0]) begin
      osc <= ~osc;
    end
  end

  scm_clock_control #(.FAIL_TIMEOUT(8)) DUT (
    .clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .oscillator_type_option(option),
    .oscillator_clock(osc), .internal_rc_clock(rc_clk), .watchdog_rc_clock(wdt_clk),
    .global_irq_enable(gie), .monitor_irq_enable(mie), .monitor_irq(monitor_irq),
    .irq(irq), .xtal_boost_en(xtal_boost_en), .internal_rc_en(internal_rc_en),
    .prescaler_src(prescaler_src), .cpu_clock_tick(cpu_clock_tick),
    .clock_fail_flag(clock_fail_flag)
  );

  // ----------------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------------
  task close_out;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task apply_reset;
    rst_n <= 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  task wr_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk);
    bus <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= IDLE;
  endtask

  task rd_reg(input string name, input logic [7:0] addr, input logic [7:0] exp);
    @(posedge clk);
    bus <= '{addr: addr, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= IDLE;
    @(negedge clk);
    check(name, rdata, exp);
  endtask

  // Bounded wait for the fail flag; running out ends the run
  task wait_flag(input logic exp, input int bound);
    int i;
    for (i = 0; i < bound && clock_fail_flag !== exp; i++) begin
      @(negedge clk);
    end
    if (clock_fail_flag !== exp) begin
      n_errors++;
      $display("ERROR fail_flag_wait expected %h seen %h", exp, clock_fail_flag);
      close_out();
    end
  endtask

  task tick_period(output int per);
    int i;
    @(negedge clk);
    for (i = 0; i < 40 && cpu_clock_tick !== 1'b1; i++) begin
      @(negedge clk);
    end
    per = 1;
    @(negedge clk);
    while (cpu_clock_tick !== 1'b1 && per < 40) begin
      per++;
      @(negedge clk);
    end
    if (per >= 40) begin
      n_errors++;
      $display("ERROR tick_wait expected %h seen %h", 1'b1, cpu_clock_tick);
      close_out();
    end
  endtask

  // ----------------------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------------------
  initial begin
    apply_reset();
    rd_reg("ctrl_reset", `SCM_ADDR_CLOCK_CONTROL, 8'hE0);
    rd_reg("status_reset", `SCM_ADDR_IRQ_STATUS, 8'h00);
    rd_reg("mask_reset", `SCM_ADDR_IRQ_MASK, 8'h00);
    rd_reg("state_reset", `SCM_ADDR_STATE, 8'h00);
    check("boost_en_reset", {7'h0, xtal_boost_en}, 8'h01);
    wr_reg(8'hB6, 8'hFF);
    rd_reg("unmapped", 8'hB6, 8'h00);
    for (int r = 0; r < 8; r++) begin
      wr_reg(`SCM_ADDR_CLOCK_CONTROL, rows[r].wdata);
      rd_reg("ctrl_row", `SCM_ADDR_CLOCK_CONTROL, rows[r].rexp);
      check("boost_en_row", {7'h0, xtal_boost_en}, {7'h0, rows[r].rexp[7]});
      check("rc_en_row", {7'h0, internal_rc_en}, {7'h0, rows[r].rexp[3]});
      check("src_row", {6'h0, prescaler_src}, {7'h0, rows[r].rexp[3] & rows[r].rexp[2]});
      tick_period(p);
      tick_period(p);
      check("tick_period", p[7:0], rows[r].period);
    end
    // Failure while running divide by 12, interrupt unmasked for the failure event
    wr_reg(`SCM_ADDR_CLOCK_CONTROL, 8'h60);
    wr_reg(`SCM_ADDR_IRQ_MASK, 8'h01);
    repeat (20) @(posedge clk);
    @(negedge clk);
    check("flag_run", {7'h0, clock_fail_flag}, 8'h00);
    osc_run <= 1'b0;
    wait_flag(1'b1, 40);
    check("src_fail", {6'h0, prescaler_src}, 8'h02);
    check("mirq_fail", {7'h0, monitor_irq}, 8'h01);
    // The sticky status bit follows the flag by one cycle
    @(negedge clk);
    check("irq_fail", {7'h0, irq}, 8'h01);
    wr_reg(`SCM_ADDR_CLOCK_CONTROL, 8'h60);
    rd_reg("ctrl_fail", `SCM_ADDR_CLOCK_CONTROL, 8'h70);
    rd_reg("state_fail", `SCM_ADDR_STATE, 8'h09);
    rd_reg("status_fail", `SCM_ADDR_IRQ_STATUS, 8'h01);
    rd_reg("status_clr", `SCM_ADDR_IRQ_STATUS, 8'h00);
    check("irq_clr", {7'h0, irq}, 8'h00);
    @(posedge clk);
    gie <= 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    check("mirq_gie_off", {7'h0, monitor_irq}, 8'h00);
    @(posedge clk);
    gie <= 1'b1;
    mie <= 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    check("mirq_mie_off", {7'h0, monitor_irq}, 8'h00);
    @(posedge clk);
    mie <= 1'b1;
    osc_run <= 1'b1;
    wait_flag(1'b0, 100);
    check("src_back", {6'h0, prescaler_src}, 8'h00);
    check("irq_masked", {7'h0, irq}, 8'h00);
    rd_reg("ctrl_back", `SCM_ADDR_CLOCK_CONTROL, 8'h60);
    rd_reg("status_back", `SCM_ADDR_IRQ_STATUS, 8'h02);
    // Internal RC as prescaler input blocks the monitor; power first, select later
    wr_reg(`SCM_ADDR_CLOCK_CONTROL, 8'h08);
    repeat (10) @(posedge clk);
    wr_reg(`SCM_ADDR_CLOCK_CONTROL, 8'h0C);
    osc_run <= 1'b0;
    repeat (30) @(posedge clk);
    @(negedge clk);
    check("flag_rc_sel", {7'h0, clock_fail_flag}, 8'h00);
    rd_reg("state_rc_sel", `SCM_ADDR_STATE, 8'h06);
    osc_run <= 1'b1;
    wr_reg(`SCM_ADDR_CLOCK_CONTROL, 8'h08);
    wr_reg(`SCM_ADDR_CLOCK_CONTROL, 8'h88);
    // Internal RC by code option: no monitor, boost and RC power without effect
    option <= `SCM_OPT_INT_RC;
    osc_run <= 1'b0;
    repeat (30) @(posedge clk);
    @(negedge clk);
    check("flag_opt_rc", {7'h0, clock_fail_flag}, 8'h00);
    check("boost_opt_rc", {7'h0, xtal_boost_en}, 8'h00);
    check("rc_en_opt_rc", {7'h0, internal_rc_en}, 8'h00);
    @(posedge clk);
    osc_run <= 1'b1;
    option <= `SCM_OPT_XTAL32K;
    repeat (6) @(posedge clk);
    @(negedge clk);
    check("boost_opt_x", {7'h0, xtal_boost_en}, 8'h01);
    check("rc_en_opt_x", {7'h0, internal_rc_en}, 8'h01);
    // Reset in mid-run brings the boost bit back
    wr_reg(`SCM_ADDR_CLOCK_CONTROL, 8'h00);
    apply_reset();
    rd_reg("ctrl_rerst", `SCM_ADDR_CLOCK_CONTROL, 8'hE0);
    rd_reg("mask_rerst", `SCM_ADDR_IRQ_MASK, 8'h00);
    close_out();
  end

endmodule
